/* File: pkg/pim_pkg.sv */
package pim_pkg;
  // Image partitions, in words
  localparam logic [15:0] PIM_PHYS1_LO = 16'h0000;
  localparam logic [15:0] PIM_MB_LO = 16'h0100;
  localparam logic [15:0] PIM_PHYS2_LO = 16'h0200;
  localparam logic [15:0] PIM_EIP_LO = 16'h04fc;
  localparam logic [15:0] PIM_RSV_LO = 16'h05fc;
  localparam logic [15:0] PIM_FLAG_HI = 16'h3000;
  // Same partitions as bit addresses
  localparam logic [15:0] PIM_MB_BIT = 16'h1000;
  localparam logic [15:0] PIM_PHYS2_BIT = 16'h2000;
  localparam logic [15:0] PIM_EIP_BIT = 16'h4fc0;
  // Mirror offsets for fieldbus read-back
  localparam logic [15:0] PIM_MIRROR_LO = 16'h0200;
  localparam logic [15:0] PIM_MIRROR_HI = 16'h1000;
  // Packing units
  localparam logic [3:0] PIM_WORD_SHIFT = 4'h4;
  localparam logic [3:0] PIM_BYTE_SHIFT = 4'h3;
  localparam logic [15:0] PIM_BYTE_ROUND = 16'h0007;
  localparam int PIM_SLOTS = 64;
  localparam logic [5:0] PIM_LAST_SLOT = 6'h3f;
  localparam logic [15:0] PIM_ZERO = 16'h0000;

  typedef enum logic [1:0] {
    PIM_KIND_NONE = 2'b00,
    PIM_KIND_CPLX = 2'b01,
    PIM_KIND_DIG = 2'b10,
    PIM_KIND_DIAG = 2'b11
  } pim_kind_t;

  typedef enum logic {PIM_DIR_IN = 1'b0, PIM_DIR_OUT = 1'b1} pim_dir_t;
  typedef enum logic {PIM_FIELDBUS = 1'b0, PIM_PROGRAM = 1'b1} pim_master_t;

  typedef enum logic [1:0] {
    PIM_AREA_IN = 2'b00,
    PIM_AREA_OUT = 2'b01,
    PIM_AREA_FLAG = 2'b10
  } pim_area_t;

  typedef enum logic [1:0] {
    PIM_W_BIT = 2'b00,
    PIM_W_BYTE = 2'b01,
    PIM_W_WORD = 2'b10,
    PIM_W_DWORD = 2'b11
  } pim_width_t;

  typedef enum logic [2:0] {
    PIM_R_PHYS1 = 3'b000,
    PIM_R_MB = 3'b001,
    PIM_R_PHYS2 = 3'b010,
    PIM_R_EIP = 3'b011,
    PIM_R_RSV = 3'b100,
    PIM_R_FLAG = 3'b101,
    PIM_R_BAD = 3'b110
  } pim_range_t;

  typedef enum logic [1:0] {
    PIM_ST_IDLE = 2'b00,
    PIM_ST_CPLX = 2'b01,
    PIM_ST_DIG = 2'b10
  } pim_state_t;
endpackage

/* File: rtl/pim_top.sv */
`timescale 1ns/100ps
// Notes on behaviour
// - Multi-byte modules placed first, from word 0
// - Digital channels then packed into 16-bit words
// - Digital bits packed back to back; no new byte after eight bits
// - Complex word per channel; digital 1/2 bits
// - Words 0-255 hold first physical range
// - Words 256-511 hold Modbus protocol variables
// - Words 512-1275 hold overflow module data
// - Words 1276-1531 hold EtherNet/IP variables
// - Words from 1532 reserved; layout can still run into them, flagging overflow
// - Word n is bytes 2n,2n+1; dword k=2k,2k+1
// - Same translation continues through second range
// - Flag space words 0-12288, bytes to 24577
// - Physical outputs rw both; inputs read-only
// - Modbus inputs: master rw, program read
// - Modbus outputs: program rw, master read
// - EtherNet/IP inputs: program read, master none
// - EtherNet/IP outputs: program rw, master none
// - Flag area rw for both parties
// - Module set change rebuilds layout; users revalidate
// - Outputs readable by master at mirror offsets
module pim_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Slot descriptor write
  input wire logic desc_valid,
  input wire logic [5:0] desc_slot,
  input wire pim_pkg::pim_kind_t desc_kind,
  input wire pim_pkg::pim_dir_t desc_dir,
  input wire logic [7:0] desc_size,
  // Slot base lookup
  input wire logic [5:0] look_slot,
  output logic [15:0] look_base_reg,
  output logic look_used_reg,
  // Layout status
  output logic layout_busy_reg,
  output logic layout_change_reg,
  output logic layout_overflow_reg,
  output logic [15:0] in_bytes_reg,
  output logic [15:0] out_bytes_reg,
  // Access request
  input wire logic acc_valid,
  input wire pim_pkg::pim_master_t acc_master,
  input wire pim_pkg::pim_area_t acc_area,
  input wire pim_pkg::pim_width_t acc_width,
  input wire logic [15:0] acc_addr,
  input wire logic [3:0] acc_bit,
  input wire logic acc_write,
  input wire logic acc_mirror,
  // Access answer
  output logic resp_valid_reg,
  output logic resp_grant_reg,
  output logic wr_en_reg,
  output pim_pkg::pim_range_t resp_range_reg,
  output logic [15:0] resp_word_reg,
  output logic [15:0] resp_byte_reg,
  output logic [15:0] resp_dword_reg
);
  import pim_pkg::*;

  logic rst_meta_reg, rst_n;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  function automatic pim_range_t pim_rng(input logic [15:0] w);
    if (w < PIM_MB_LO) pim_rng = PIM_R_PHYS1;
    else if (w < PIM_PHYS2_LO) pim_rng = PIM_R_MB;
    else if (w < PIM_EIP_LO) pim_rng = PIM_R_PHYS2;
    else if (w < PIM_RSV_LO) pim_rng = PIM_R_EIP;
    else pim_rng = PIM_R_RSV;
  endfunction

  // Physical data may not straddle the protocol window at 256..511
  function automatic logic [15:0] pim_fit(input logic [15:0] p, input logic [15:0] n,
                                          input logic [15:0] lo, input logic [15:0] hi);
    pim_fit = (p < lo && p + n > lo) ? hi : p;
  endfunction

  // Descriptor store; any change flags a rebuild
  pim_kind_t kind_mem [PIM_SLOTS];
  pim_dir_t dir_mem [PIM_SLOTS];
  logic [7:0] size_mem [PIM_SLOTS];
  logic [15:0] base_mem [PIM_SLOTS];
  logic dirty_reg;
  pim_state_t state_reg;
  logic [5:0] slot_reg;
  logic [15:0] wptr_reg [2];
  logic [15:0] bptr_reg [2];

  always_ff @(posedge ref_clk) begin
    if (desc_valid) begin
      kind_mem[desc_slot] <= desc_kind;
      dir_mem[desc_slot] <= desc_dir;
      size_mem[desc_slot] <= desc_size;
    end
  end

  wire start = (state_reg == PIM_ST_IDLE) && dirty_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) dirty_reg <= 1'b1;
    else dirty_reg <= desc_valid | (dirty_reg & ~start);
  end

  // Rebuild walk: complex pass, then digital pass
  pim_kind_t cur_kind;
  logic cur_dir;
  logic [15:0] cur_n, cplx_base, dig_base;
  always_comb begin
    cur_kind = kind_mem[slot_reg];
    cur_dir = dir_mem[slot_reg];
    cur_n = (cur_kind == PIM_KIND_DIAG) ? {7'h00, size_mem[slot_reg], 1'b0}
                                        : {8'h00, size_mem[slot_reg]};
    cplx_base = pim_fit(wptr_reg[cur_dir], cur_n, PIM_MB_LO, PIM_PHYS2_LO);
    dig_base = pim_fit(bptr_reg[cur_dir], cur_n, PIM_MB_BIT, PIM_PHYS2_BIT);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= PIM_ST_IDLE;
      slot_reg <= 6'h00;
      layout_change_reg <= 1'b0;
      layout_overflow_reg <= 1'b0;
      for (int d = 0; d < 2; d++) begin
        wptr_reg[d] <= PIM_PHYS1_LO;
        bptr_reg[d] <= PIM_ZERO;
      end
    end else begin
      layout_change_reg <= 1'b0;
      case (state_reg)
        PIM_ST_IDLE: begin
          if (start) begin
            state_reg <= PIM_ST_CPLX;
            slot_reg <= 6'h00;
            layout_overflow_reg <= 1'b0;
            for (int d = 0; d < 2; d++) wptr_reg[d] <= PIM_PHYS1_LO;
          end
        end
        PIM_ST_CPLX: begin
          if (cur_kind == PIM_KIND_CPLX) begin
            wptr_reg[cur_dir] <= cplx_base + cur_n;
            if (cplx_base + cur_n > PIM_EIP_LO) layout_overflow_reg <= 1'b1;
          end
          slot_reg <= slot_reg + 6'h01;
          if (slot_reg == PIM_LAST_SLOT) begin
            state_reg <= PIM_ST_DIG;
            for (int d = 0; d < 2; d++) bptr_reg[d] <= wptr_reg[d] << PIM_WORD_SHIFT;
            if (cur_kind == PIM_KIND_CPLX)
              bptr_reg[cur_dir] <= (cplx_base + cur_n) << PIM_WORD_SHIFT;
          end
        end
        PIM_ST_DIG: begin
          if (cur_kind == PIM_KIND_DIG || cur_kind == PIM_KIND_DIAG) begin
            bptr_reg[cur_dir] <= dig_base + cur_n;
            if (dig_base + cur_n > PIM_EIP_BIT) layout_overflow_reg <= 1'b1;
          end
          slot_reg <= slot_reg + 6'h01;
          if (slot_reg == PIM_LAST_SLOT) begin
            state_reg <= PIM_ST_IDLE;
            layout_change_reg <= 1'b1;
          end
        end
        default: state_reg <= PIM_ST_IDLE;
      endcase
    end
  end

  // Bases kept as bit addresses; complex ones are word aligned
  always_ff @(posedge ref_clk) begin
    if (state_reg == PIM_ST_CPLX && cur_kind == PIM_KIND_CPLX)
      base_mem[slot_reg] <= cplx_base << PIM_WORD_SHIFT;
    else if (state_reg == PIM_ST_DIG && cur_kind != PIM_KIND_CPLX)
      base_mem[slot_reg] <= (cur_kind == PIM_KIND_NONE) ? PIM_ZERO : dig_base;
  end

  // Bases are stale while busy; users wait for the change pulse
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      look_base_reg <= PIM_ZERO;
      look_used_reg <= 1'b0;
      layout_busy_reg <= 1'b1;
      in_bytes_reg <= PIM_ZERO;
      out_bytes_reg <= PIM_ZERO;
    end else begin
      look_base_reg <= base_mem[look_slot];
      look_used_reg <= (kind_mem[look_slot] != PIM_KIND_NONE) && !dirty_reg;
      layout_busy_reg <= (state_reg != PIM_ST_IDLE) || dirty_reg;
      in_bytes_reg <= (bptr_reg[PIM_DIR_IN] + PIM_BYTE_ROUND) >> PIM_BYTE_SHIFT;
      out_bytes_reg <= (bptr_reg[PIM_DIR_OUT] + PIM_BYTE_ROUND) >> PIM_BYTE_SHIFT;
    end
  end

  // Access translation and permission check
  logic [15:0] a_word, a_last;
  logic a_hi, a_ok;
  pim_area_t a_area;
  pim_range_t a_rng;
  always_comb begin
    a_area = acc_area;
    a_hi = 1'b0;
    case (acc_width)
      PIM_W_BIT: begin
        a_word = acc_addr;
        a_hi = acc_bit[3];
      end
      PIM_W_BYTE: begin
        a_word = acc_addr >> 1;
        a_hi = acc_addr[0];
      end
      PIM_W_DWORD: a_word = acc_addr << 1;
      default: a_word = acc_addr;
    endcase
    if (acc_mirror) begin
      a_area = PIM_AREA_OUT;
      a_word = (acc_addr >= PIM_MIRROR_HI) ? acc_addr - PIM_MIRROR_HI
                                           : acc_addr - PIM_MIRROR_LO;
    end
    a_last = (acc_width == PIM_W_DWORD && !acc_mirror) ? a_word + 16'h0001 : a_word;
    a_rng = pim_rng(a_word);
    if (a_area == PIM_AREA_FLAG) a_rng = (a_last <= PIM_FLAG_HI) ? PIM_R_FLAG : PIM_R_BAD;
    else if (pim_rng(a_last) != a_rng) a_rng = PIM_R_BAD;
    a_ok = 1'b0;
    if (acc_mirror) begin
      a_ok = acc_master == PIM_FIELDBUS && !acc_write && acc_width == PIM_W_WORD &&
             acc_addr >= PIM_MIRROR_LO && a_rng != PIM_R_EIP && a_rng != PIM_R_RSV &&
             a_rng != PIM_R_BAD;
    end else begin
      case (a_rng)
        PIM_R_PHYS1, PIM_R_PHYS2: a_ok = (a_area == PIM_AREA_OUT) || !acc_write;
        PIM_R_MB: begin
          if (a_area == PIM_AREA_IN) a_ok = (acc_master == PIM_FIELDBUS) || !acc_write;
          else a_ok = (acc_master == PIM_PROGRAM) || !acc_write;
        end
        PIM_R_EIP: begin
          if (a_area == PIM_AREA_IN) a_ok = (acc_master == PIM_PROGRAM) && !acc_write;
          else a_ok = (acc_master == PIM_PROGRAM);
        end
        PIM_R_FLAG: a_ok = 1'b1;
        default: a_ok = 1'b0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      resp_valid_reg <= 1'b0;
      resp_grant_reg <= 1'b0;
      wr_en_reg <= 1'b0;
      resp_range_reg <= PIM_R_BAD;
      resp_word_reg <= PIM_ZERO;
      resp_byte_reg <= PIM_ZERO;
      resp_dword_reg <= PIM_ZERO;
    end else begin
      resp_valid_reg <= acc_valid;
      resp_grant_reg <= acc_valid && a_ok;
      wr_en_reg <= acc_valid && a_ok && acc_write;
      if (acc_valid) begin
        resp_range_reg <= a_rng;
        resp_word_reg <= a_word;
        resp_byte_reg <= {a_word[14:0], a_hi};
        resp_dword_reg <= a_word >> 1;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  wr_only_grant_a: assert property (wr_en_reg |-> resp_grant_reg && resp_valid_reg)
    else $error("write enable without grant");
  in_phys_ro_a: assert property (acc_valid && acc_write && !acc_mirror && acc_area == PIM_AREA_IN
    && acc_width == PIM_W_WORD && acc_addr < PIM_MB_LO |=> !resp_grant_reg && !wr_en_reg)
    else $error("physical input written");
  mb_out_fb_a: assert property (acc_valid && acc_write && !acc_mirror && acc_area == PIM_AREA_OUT
    && acc_master == PIM_FIELDBUS && acc_width == PIM_W_WORD && acc_addr >= PIM_MB_LO
    && acc_addr < PIM_PHYS2_LO |=> !resp_grant_reg)
    else $error("master wrote protocol output");
  eip_fb_deny_a: assert property (acc_valid && !acc_mirror && acc_master == PIM_FIELDBUS
    && acc_area != PIM_AREA_FLAG && acc_width == PIM_W_WORD && acc_addr >= PIM_EIP_LO
    && acc_addr < PIM_RSV_LO |=> !resp_grant_reg)
    else $error("master reached ethernet ip variables");
  flag_rw_a: assert property (acc_valid && !acc_mirror && acc_area == PIM_AREA_FLAG
    && acc_width == PIM_W_WORD && acc_addr <= PIM_FLAG_HI |=> resp_grant_reg)
    else $error("flag access refused");
  reserved_a: assert property (resp_grant_reg && resp_range_reg != PIM_R_FLAG
    |-> resp_word_reg < PIM_RSV_LO)
    else $error("reserved space granted");
  byte_map_a: assert property (acc_valid && acc_width == PIM_W_WORD && !acc_mirror
    |=> resp_byte_reg == {resp_word_reg[14:0], 1'b0} && resp_dword_reg == $past(acc_addr) >> 1)
    else $error("byte or dword translation wrong");
  mirror_a: assert property (acc_valid && acc_mirror && acc_master == PIM_FIELDBUS && !acc_write
    && acc_width == PIM_W_WORD && acc_addr >= PIM_MIRROR_LO && acc_addr < PIM_MIRROR_LO + PIM_MB_LO
    |=> resp_grant_reg && resp_word_reg == $past(acc_addr) - PIM_MIRROR_LO)
    else $error("mirror read not honoured");
  rebuild_a: assert property (desc_valid && state_reg == PIM_ST_IDLE
    |=> ##[1:140] layout_change_reg)
    else $error("layout not rebuilt");

  rebuild_c: cover property (layout_change_reg && !layout_overflow_reg);
  grant_wr_c: cover property (wr_en_reg);
  deny_c: cover property (resp_valid_reg && !resp_grant_reg);
  mirror_c: cover property (acc_valid && acc_mirror ##1 resp_grant_reg);
endmodule // pim_top

/* File: sim/pim_partner.sv */
`timescale 1ns/100ps
module pim_partner (
  // Clock and layout state
  input wire logic ref_clk,
  input wire logic layout_busy_reg,
  // Requests of fieldbus master and control program
  output logic acc_valid,
  output pim_pkg::pim_master_t acc_master,
  output pim_pkg::pim_area_t acc_area,
  output pim_pkg::pim_width_t acc_width,
  output logic [15:0] acc_addr,
  output logic [3:0] acc_bit,
  output logic acc_write,
  output logic acc_mirror
);
  import pim_pkg::*;
  initial begin
    acc_valid = 1'b0;
    acc_master = PIM_FIELDBUS;
    acc_area = PIM_AREA_IN;
    acc_width = PIM_W_WORD;
    acc_addr = 16'h0000;
    acc_bit = 4'h0;
    acc_write = 1'b0;
    acc_mirror = 1'b0;
  end
  // One request, then gap idle cycles; idle address shows inverse, not stale
  task automatic send(input int m, ar, wd, a, bt, wr, mir, gap);
    // Addresses are void while the layout is being rebuilt
    while (layout_busy_reg !== 1'b0) @(posedge ref_clk);
    @(posedge ref_clk);
    acc_master <= pim_master_t'(m[0]);
    acc_area <= pim_area_t'(ar[1:0]);
    acc_width <= pim_width_t'(wd[1:0]);
    acc_addr <= a[15:0];
    acc_bit <= bt[3:0];
    acc_write <= wr[0];
    acc_mirror <= mir[0];
    acc_valid <= 1'b1;
    repeat (gap) begin
      @(posedge ref_clk);
      acc_valid <= 1'b0;
      acc_addr <= ~a[15:0];
    end
  endtask
endmodule // pim_partner

/* File: sim/process_image_address_map_tb.sv */
`timescale 1ns/100ps
module process_image_address_map_tb;
  import pim_pkg::*;
  typedef struct {int g; int r; int w; int b; int d; int wr; int chk;} pim_exp_t;
  logic ref_clk, resetn, desc_valid, acc_valid, acc_write, acc_mirror;
  logic look_used_reg, layout_busy_reg, layout_change_reg, layout_overflow_reg;
  logic resp_valid_reg, resp_grant_reg, wr_en_reg;
  logic [5:0] desc_slot, look_slot;
  logic [7:0] desc_size;
  logic [3:0] acc_bit;
  logic [15:0] look_base_reg, in_bytes_reg, out_bytes_reg, acc_addr;
  logic [15:0] resp_word_reg, resp_byte_reg, resp_dword_reg;
  pim_kind_t desc_kind;
  pim_dir_t desc_dir;
  pim_master_t acc_master;
  pim_area_t acc_area;
  pim_width_t acc_width;
  pim_range_t resp_range_reg;
  int n_tests, n_mismatch, kd[64], dr[64], sz[64], bs[64];
  pim_exp_t expq[$];
  // master, area, width, address, bit, write, mirror
  int tbl [25][7] = '{'{1,1,2,5,0,1,0}, '{0,0,2,10,0,1,0}, '{0,0,2,10,0,0,0},
    '{1,0,2,300,0,1,0}, '{0,0,2,300,0,1,0}, '{0,1,2,511,0,1,0}, '{1,1,2,511,0,1,0},
    '{0,1,2,511,0,0,0}, '{0,0,2,1276,0,0,0}, '{1,0,2,1276,0,0,0}, '{1,0,2,1276,0,1,0},
    '{0,1,2,1531,0,1,0}, '{1,1,2,1531,0,1,0}, '{1,1,2,1532,0,0,0}, '{0,2,2,12288,0,1,0},
    '{1,2,2,12289,0,0,0}, '{1,2,1,24575,0,1,0}, '{1,1,1,2551,0,1,0}, '{0,1,3,637,0,0,0},
    '{1,0,0,255,8,0,0}, '{0,1,2,'h205,0,0,1}, '{0,1,2,'h1258,0,0,1}, '{0,1,2,'h714,0,0,1},
    '{0,1,2,'h205,0,1,1}, '{1,1,2,'h205,0,0,1}};

  pim_top dut (.ref_clk, .resetn, .desc_valid, .desc_slot, .desc_kind, .desc_dir,
    .desc_size, .look_slot, .look_base_reg, .look_used_reg, .layout_busy_reg,
    .layout_change_reg, .layout_overflow_reg, .in_bytes_reg, .out_bytes_reg, .acc_valid,
    .acc_master, .acc_area, .acc_width, .acc_addr, .acc_bit, .acc_write, .acc_mirror,
    .resp_valid_reg, .resp_grant_reg, .wr_en_reg, .resp_range_reg, .resp_word_reg,
    .resp_byte_reg, .resp_dword_reg);
  pim_partner u_part (.ref_clk, .layout_busy_reg, .acc_valid, .acc_master, .acc_area,
    .acc_width, .acc_addr, .acc_bit, .acc_write, .acc_mirror);

  always #5 ref_clk = ~ref_clk;

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  function automatic pim_exp_t model(input int m, ar, wd, a, bt, wr, mir);
    pim_exp_t e;
    int w, hi, rd, rw;
    w = (wd == 1) ? a / 2 : (wd == 3) ? a * 2 : a;
    hi = (wd == 1) ? a % 2 : (wd == 0) ? int'(bt >= 8) : 0;
    e.chk = 1;
    if (mir) begin
      e.chk = int'(m == 0 && !wr && wd == 2 && a >= 'h200);
      w = (a >= 'h1000) ? a - 'h1000 : a - 'h200;
      ar = 1;
    end
    if (ar == 2) e.r = (w + int'(wd == 3) <= 12288) ? 5 : 6;
    else e.r = (w < 256) ? 0 : (w < 512) ? 1 : (w < 1276) ? 2 : (w < 1532) ? 3 : 4;
    rd = 0;
    rw = 0;
    case (e.r)
      0, 2: begin rd = 1; rw = int'(ar == 1); end
      1: begin rd = 1; rw = int'((ar == 0) == (m == 0)); end
      3: begin rd = m; rw = int'(m == 1 && ar == 1); end
      5: begin rd = 1; rw = 1; end
      default: ;
    endcase
    e.g = e.chk & (wr ? rw : rd);
    e.w = w;
    e.b = 2 * w + hi;
    e.d = w / 2;
    e.wr = wr;
    return e;
  endfunction

  task automatic req(input int m, ar, wd, a, bt, wr, mir, gap);
    expq.push_back(model(m, ar, wd, a, bt, wr, mir));
    u_part.send(m, ar, wd, a, bt, wr, mir, gap);
  endtask

  always @(negedge ref_clk) begin
    pim_exp_t e;
    if (resp_valid_reg === 1'b1) begin
      if (expq.size() == 0) check("spare answer", 16'h1, 16'h0);
      else begin
        e = expq.pop_front();
        check("grant", {15'h0, resp_grant_reg}, 16'(e.g));
        check("wr_en", {15'h0, wr_en_reg}, 16'(e.g & e.wr));
        if (e.chk) check("range", {13'h0, resp_range_reg}, 16'(e.r));
        if (e.g) check("word", resp_word_reg, 16'(e.w));
        if (e.g) check("byte", resp_byte_reg, 16'(e.b));
        if (e.g) check("dword", resp_dword_reg, 16'(e.d));
      end
    end
  end

  task automatic wait_change();
    int i;
    i = 0;
    while (layout_change_reg !== 1'b1 && i < 1000) begin
      @(negedge ref_clk);
      i++;
    end
    check("rebuilt", {15'h0, layout_change_reg}, 16'h1);
    @(negedge ref_clk);
    check("one pulse", {15'h0, layout_change_reg}, 16'h0);
    check("idle", {15'h0, layout_busy_reg}, 16'h0);
  endtask

  function automatic void put(input int s, k, d, z);
    kd[s] = k;
    dr[s] = d;
    sz[s] = z;
  endfunction

  task automatic load(input string name);
    int p, b, n, ovf;
    int nb[2];
    for (int s = 0; s < 64; s++) begin
      @(posedge ref_clk);
      desc_valid <= 1'b1;
      desc_slot <= s[5:0];
      desc_kind <= pim_kind_t'(kd[s][1:0]);
      desc_dir <= pim_dir_t'(dr[s][0]);
      desc_size <= sz[s][7:0];
    end
    @(posedge ref_clk);
    desc_valid <= 1'b0;
    look_slot <= 6'h0;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    check("busy", {15'h0, layout_busy_reg}, 16'h1);
    check("stale use", {15'h0, look_used_reg}, 16'h0);
    // Writes landing mid-walk queue a second rebuild; judge only the last one
    repeat (130) @(negedge ref_clk);
    wait_change();
    ovf = 0;
    for (int d = 0; d < 2; d++) begin
      p = 0;
      for (int s = 0; s < 64; s++) begin
        if (kd[s] == 1 && dr[s] == d) begin
          if (p < 256 && p + sz[s] > 256) p = 512;
          bs[s] = p * 16;
          p += sz[s];
        end
      end
      b = p * 16;
      for (int s = 0; s < 64; s++) begin
        if (kd[s] >= 2 && dr[s] == d) begin
          n = (kd[s] == 3) ? 2 * sz[s] : sz[s];
          if (b < 4096 && b + n > 4096) b = 8192;
          bs[s] = b;
          b += n;
        end
      end
      nb[d] = (b + 7) / 8;
      if (b > 20416) ovf = 1;
    end
    for (int s = 0; s < 64; s++) begin
      @(posedge ref_clk);
      look_slot <= s[5:0];
      @(posedge ref_clk);
      @(negedge ref_clk);
      check("used", {15'h0, look_used_reg}, 16'(kd[s] != 0));
      if (kd[s] != 0) check("base", look_base_reg, 16'(bs[s]));
    end
    check("in bytes", in_bytes_reg, 16'(nb[0]));
    check("out bytes", out_bytes_reg, 16'(nb[1]));
    check("overflow", {15'h0, layout_overflow_reg}, 16'(ovf));
    $display("test %s done", name);
  endtask

  initial begin
    #200000;
    n_mismatch++;
    conclude();
  end

  initial begin
    int m, ar, wd, a;
    ref_clk = 1'b0;
    resetn = 1'b0;
    desc_valid = 1'b0;
    desc_slot = 6'h00;
    desc_kind = PIM_KIND_NONE;
    desc_dir = PIM_DIR_IN;
    desc_size = 8'h00;
    look_slot = 6'h00;
    n_tests = 0;
    n_mismatch = 0;
    void'($urandom(32'hfd53));
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    wait_change();
    for (int s = 0; s < 64; s++) put(s, 0, 0, 0);
    put(0, 1, 0, 3);
    put(1, 2, 0, 10);
    put(2, 1, 0, 2);
    put(3, 3, 1, 3);
    put(4, 1, 1, 4);
    put(5, 2, 1, 16);
    load("small layout");
    for (int i = 0; i < 25; i++) begin
      req(tbl[i][0], tbl[i][1], tbl[i][2], tbl[i][3], tbl[i][4], tbl[i][5], tbl[i][6], i % 5 / 4 * 3);
    end
    $display("test directed access done");
    for (int i = 0; i < 300; i++) begin
      m = $urandom_range(1);
      ar = $urandom_range(2);
      wd = $urandom_range(3);
      a = (ar == 2) ? $urandom_range(6000) : $urandom_range(1600);
      if (wd == 1) a = a * 2 + $urandom_range(1);
      req(m, ar, wd, a, $urandom_range(15), $urandom_range(1), 0, $urandom_range(1) + (i / 299));
    end
    repeat (4) @(negedge ref_clk);
    check("unanswered", 16'(expq.size()), 16'h0);
    $display("test random access done");
    put(6, 1, 1, 250);
    put(7, 1, 1, 10);
    load("gap skip layout");
    for (int s = 8; s < 12; s++) put(s, 1, 0, 255);
    load("overflow layout");
    conclude();
  end
endmodule // process_image_address_map_tb
